// *** lmm_regs.svh ***
`ifndef LMM_REGS_SVH
`define LMM_REGS_SVH
// Major opcodes and sub-fields
`define LMM_OP_SPECIAL  6'h00
`define LMM_OP_LWU      6'h2F
`define LMM_OP_COP_GRP  4'h4
`define LMM_COP_MF      5'h00
`define LMM_COP_MT      5'h04
`define LMM_COP_SYSCTL  2'h0
`define LMM_COP_RSVD    2'h3
`define LMM_FN_MOVE_FROM_PRODUCT_HIGH     6'h10
`define LMM_FN_MOVE_TO_PRODUCT_HIGH     6'h11
`define LMM_FN_MOVE_FROM_PRODUCT_LOW     6'h12
`define LMM_FN_MOVE_TO_PRODUCT_LOW     6'h13
`define LMM_FN_SIGNED_MULTIPLY     6'h18
`define LMM_FN_UNSIGNED_MULTIPLY    6'h19
`define LMM_FN_OR       6'h25
`define LMM_FN_NOR      6'h27
// Exception codes reported on exc_code
`define LMM_EXC_ADDR    4'h4
`define LMM_EXC_REFILL  4'h2
`define LMM_EXC_INVALID 4'h3
`define LMM_EXC_BUS     4'h7
`define LMM_EXC_RSVD    4'hA
`define LMM_EXC_UNUSE   4'hB
// Cycles the product registers stay undefined before a write commits
`define LMM_HILO_WAIT   2'h2
`endif

// *** lmm_pkg.sv ***
package lmm_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_COPRD, ST_HILO} lmm_st_t;
endpackage

// *** lmm_exec.sv ***
// Function
// - Zero-extending word load reads the word at base plus sign-extended offset and clears the upper half.
// - A load address with either low bit set raises an address error and no load is issued.
// - Translation refill, translation invalid, bus error and address error are each detected and reported.
// - Move from system control coprocessor sign-extends bit 31 and writes the register one cycle after the read.
// - Coprocessor moves naming coprocessor 3 raise reserved instruction, other unusable ones raise unusable.
// - Move to product high writes the source and, right after a multiply, leaves product low undefined.
// - Move to product low writes the source and, right after a multiply, leaves product high undefined.
// - Signed multiply puts sign-extended low and high words into the product registers without overflow.
// - Unsigned multiply puts the low and high words into the product registers without overflow.
// - Register NOR writes the 64-bit NOR of both sources to the destination.
// - Register OR writes the 64-bit OR of both sources to the destination.
`timescale 1ns/10ps
`include "lmm_regs.svh"
module lmm_exec (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 ins_valid,
   output logic                      ins_ready,
   input  wire logic [31:0]          ins_word,
   input  wire logic [63:0]          src_a,
   input  wire logic [63:0]          src_b,
   input  wire logic [3:0]           cop_usable,
   output logic                      mem_req,
   output logic [63:0]               mem_addr,
   input  wire logic                 mem_ack,
   input  wire logic [31:0]          mem_rdata,
   input  wire logic                 mem_tlb_refill,
   input  wire logic                 mem_tlb_invalid,
   input  wire logic                 mem_bus_err,
   output logic [1:0]                cop_rd_num,
   output logic [4:0]                cop_rd_idx,
   input  wire logic [63:0]          cop_rd_data,
   output logic                      cp0_wr_en,
   output logic [4:0]                cp0_wr_idx,
   output logic [63:0]               cp0_wr_data,
   output logic                      cop_wr_en,
   output logic [1:0]                cop_wr_num,
   output logic [3:0]                cop_wr_idx,
   output logic                      cop_wr_hi,
   output logic [31:0]               cop_wr_data,
   output logic                      gpr_wr_en,
   output logic [4:0]                gpr_wr_idx,
   output logic [63:0]               gpr_wr_data,
   output logic                      exc_valid,
   output logic [3:0]                exc_code,
   output logic [63:0]               hi_out,
   output logic [63:0]               lo_out,
   output logic                      hi_valid,
   output logic                      lo_valid
);
   import lmm_pkg::*;

   typedef struct packed {
      lmm_st_t     st;
      logic [1:0]  cnt;
      logic [63:0] hi;
      logic [63:0] lo;
      logic [63:0] p_hi;
      logic [63:0] p_lo;
      logic        p_whi;
      logic        p_wlo;
      logic        p_kill;
      logic        hi_ok;
      logic        lo_ok;
      logic        mul_since;
      logic        wr_en;
      logic [4:0]  wr_idx;
      logic [63:0] wr_data;
      logic        mreq;
      logic [63:0] maddr;
      logic        exc;
      logic [3:0]  code;
      logic        cp0_we;
      logic        cop_we;
      logic [1:0]  cnum;
      logic [4:0]  cidx;
      logic [63:0] cdata;
   } lmm_state_t;

   lmm_state_t s_r;
   lmm_state_t s_nxt;

   logic [5:0]         op;
   logic [5:0]         fn;
   logic [4:0]         f_rs;
   logic [4:0]         f_rt;
   logic [4:0]         f_rd;
   logic [1:0]         z;
   logic [63:0]        ea;
   logic signed [63:0] sprod;
   logic [63:0]        uprod;

   assign op    = ins_word[31:26];
   assign f_rs  = ins_word[25:21];
   assign f_rt  = ins_word[20:16];
   assign f_rd  = ins_word[15:11];
   assign fn    = ins_word[5:0];
   assign z     = ins_word[27:26];
   assign ea    = src_a + {{48{ins_word[15]}}, ins_word[15:0]};
   assign sprod = $signed(src_a[31:0]) * $signed(src_b[31:0]);
   assign uprod = {32'h0, src_a[31:0]} * {32'h0, src_b[31:0]};
   always_comb begin
      s_nxt        = s_r;
      s_nxt.wr_en  = 1'b0;
      s_nxt.mreq   = 1'b0;
      s_nxt.exc    = 1'b0;
      s_nxt.cp0_we = 1'b0;
      s_nxt.cop_we = 1'b0;
      unique case (s_r.st)
         ST_IDLE: begin
            if (ins_valid && op == `LMM_OP_LWU) begin
               if (ea[1:0] != 2'h0) begin
                  s_nxt.exc  = 1'b1;
                  s_nxt.code = `LMM_EXC_ADDR;
               end else begin
                  s_nxt.mreq   = 1'b1;
                  s_nxt.maddr  = ea;
                  s_nxt.wr_idx = f_rt;
                  s_nxt.st     = ST_LOAD;
               end
            end else if (ins_valid && op[5:2] == `LMM_OP_COP_GRP &&
                         (f_rs == `LMM_COP_MF || f_rs == `LMM_COP_MT)) begin
               if (z == `LMM_COP_RSVD) begin
                  s_nxt.exc  = 1'b1;
                  s_nxt.code = `LMM_EXC_RSVD;
               end else if (!cop_usable[z]) begin
                  s_nxt.exc  = 1'b1;
                  s_nxt.code = `LMM_EXC_UNUSE;
               end else if (f_rs == `LMM_COP_MF) begin
                  s_nxt.cnum   = z;
                  s_nxt.cidx   = f_rd;
                  s_nxt.wr_idx = f_rt;
                  s_nxt.st     = ST_COPRD;
               end else begin
                  s_nxt.cnum   = z;
                  s_nxt.cidx   = f_rd;
                  s_nxt.cdata  = src_b;
                  s_nxt.cp0_we = (z == `LMM_COP_SYSCTL);
                  s_nxt.cop_we = (z != `LMM_COP_SYSCTL);
               end
            end else if (ins_valid && op == `LMM_OP_SPECIAL) begin
               unique case (fn)
                  `LMM_FN_MOVE_FROM_PRODUCT_HIGH, `LMM_FN_MOVE_FROM_PRODUCT_LOW: begin
                     s_nxt.wr_en     = 1'b1;
                     s_nxt.wr_idx    = f_rd;
                     s_nxt.wr_data   = (fn == `LMM_FN_MOVE_FROM_PRODUCT_HIGH) ? s_r.hi : s_r.lo;
                     s_nxt.mul_since = 1'b0;
                  end
                  `LMM_FN_MOVE_TO_PRODUCT_HIGH, `LMM_FN_MOVE_TO_PRODUCT_LOW: begin
                     s_nxt.p_hi      = src_a;
                     s_nxt.p_lo      = src_a;
                     s_nxt.p_whi     = (fn == `LMM_FN_MOVE_TO_PRODUCT_HIGH);
                     s_nxt.p_wlo     = (fn == `LMM_FN_MOVE_TO_PRODUCT_LOW);
                     s_nxt.p_kill    = s_r.mul_since;
                     s_nxt.mul_since = 1'b0;
                     s_nxt.hi_ok     = s_r.hi_ok && fn == `LMM_FN_MOVE_TO_PRODUCT_LOW;
                     s_nxt.lo_ok     = s_r.lo_ok && fn == `LMM_FN_MOVE_TO_PRODUCT_HIGH;
                     s_nxt.cnt       = `LMM_HILO_WAIT;
                     s_nxt.st        = ST_HILO;
                  end
                  `LMM_FN_SIGNED_MULTIPLY, `LMM_FN_UNSIGNED_MULTIPLY: begin
                     if (fn == `LMM_FN_SIGNED_MULTIPLY) begin
                        s_nxt.p_lo = {{32{sprod[31]}}, sprod[31:0]};
                        s_nxt.p_hi = {{32{sprod[63]}}, sprod[63:32]};
                     end else begin
                        s_nxt.p_lo = {{32{uprod[31]}}, uprod[31:0]};
                        s_nxt.p_hi = {{32{uprod[63]}}, uprod[63:32]};
                     end
                     s_nxt.p_whi     = 1'b1;
                     s_nxt.p_wlo     = 1'b1;
                     s_nxt.p_kill    = 1'b0;
                     s_nxt.mul_since = 1'b1;
                     s_nxt.hi_ok     = 1'b0;
                     s_nxt.lo_ok     = 1'b0;
                     s_nxt.cnt       = `LMM_HILO_WAIT;
                     s_nxt.st        = ST_HILO;
                  end
                  `LMM_FN_OR, `LMM_FN_NOR: begin
                     s_nxt.wr_en   = 1'b1;
                     s_nxt.wr_idx  = f_rd;
                     s_nxt.wr_data = (fn == `LMM_FN_OR) ? (src_a | src_b) : ~(src_a | src_b);
                  end
                  default: ;
               endcase
            end
         end
         ST_LOAD: begin
            // Faults are ranked so a single code is reported per load
            if (mem_ack) begin
               s_nxt.st = ST_IDLE;
               if (mem_tlb_refill || mem_tlb_invalid || mem_bus_err) begin
                  s_nxt.exc  = 1'b1;
                  s_nxt.code = mem_tlb_refill ? `LMM_EXC_REFILL :
                               mem_tlb_invalid ? `LMM_EXC_INVALID : `LMM_EXC_BUS;
               end else begin
                  s_nxt.wr_en   = 1'b1;
                  s_nxt.wr_data = {32'h0, mem_rdata};
               end
            end
         end
         ST_COPRD: begin
            s_nxt.wr_en   = 1'b1;
            s_nxt.wr_data = {{32{cop_rd_data[31]}}, cop_rd_data[31:0]};
            s_nxt.st      = ST_IDLE;
         end
         ST_HILO: begin
            s_nxt.cnt = s_r.cnt - 2'h1;
            if (s_r.cnt == 2'h1) begin
               s_nxt.st = ST_IDLE;
               if (s_r.p_whi) begin
                  s_nxt.hi    = s_r.p_hi;
                  s_nxt.hi_ok = 1'b1;
               end
               if (s_r.p_wlo) begin
                  s_nxt.lo    = s_r.p_lo;
                  s_nxt.lo_ok = 1'b1;
               end
               // The untouched half is flagged undefined at commit when a multiply preceded the move
               if (s_r.p_kill && s_r.p_whi) s_nxt.lo_ok = 1'b0;
               if (s_r.p_kill && s_r.p_wlo) s_nxt.hi_ok = 1'b0;
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign ins_ready   = (s_r.st == ST_IDLE);
   assign mem_req     = s_r.mreq;
   assign mem_addr    = s_r.maddr;
   assign cop_rd_num  = s_r.cnum;
   assign cop_rd_idx  = s_r.cidx;
   assign cp0_wr_en   = s_r.cp0_we;
   assign cp0_wr_idx  = s_r.cidx;
   assign cp0_wr_data = s_r.cdata;
   assign cop_wr_en   = s_r.cop_we;
   assign cop_wr_num  = s_r.cnum;
   assign cop_wr_idx  = s_r.cidx[4:1];
   assign cop_wr_hi   = s_r.cidx[0];
   assign cop_wr_data = s_r.cdata[31:0];
   assign gpr_wr_en   = s_r.wr_en;
   assign gpr_wr_idx  = s_r.wr_idx;
   assign gpr_wr_data = s_r.wr_data;
   assign exc_valid   = s_r.exc;
   assign exc_code    = s_r.code;
   assign hi_out      = s_r.hi;
   assign lo_out      = s_r.lo;
   assign hi_valid    = s_r.hi_ok;
   assign lo_valid    = s_r.lo_ok;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire fire = ins_valid && ins_ready;
   lwu_zero_ext_a: assert property ($past(s_r.st) == ST_LOAD && gpr_wr_en |-> gpr_wr_data[63:32] == 32'h0)
      else $error("load upper half not cleared");
   lwu_misalign_a: assert property (fire && op == `LMM_OP_LWU && ea[1:0] != 2'h0
      |=> exc_valid && exc_code == `LMM_EXC_ADDR && !mem_req) else $error("misaligned load not trapped");
   load_fault_a: assert property (s_r.st == ST_LOAD && mem_ack && mem_tlb_refill
      |=> exc_valid && exc_code == `LMM_EXC_REFILL && !gpr_wr_en) else $error("refill fault not reported");
   coprd_sext_a: assert property (s_r.st == ST_COPRD
      |=> gpr_wr_en && gpr_wr_data == {{32{$past(cop_rd_data[31])}}, $past(cop_rd_data[31:0])})
      else $error("coprocessor read not sign extended");
   cop3_rsvd_a: assert property (fire && op[5:2] == `LMM_OP_COP_GRP && z == `LMM_COP_RSVD
      && (f_rs == `LMM_COP_MF || f_rs == `LMM_COP_MT)
      |=> exc_valid && exc_code == `LMM_EXC_RSVD && !cop_wr_en) else $error("coprocessor 3 move not reserved");
   move_to_product_high_kill_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_MOVE_TO_PRODUCT_HIGH && s_r.mul_since
      |-> ##3 hi_out == $past(src_a, 3) && hi_valid && !lo_valid) else $error("move to high after multiply wrong");
   move_to_product_low_kill_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_MOVE_TO_PRODUCT_LOW && s_r.mul_since
      |-> ##3 lo_out == $past(src_a, 3) && lo_valid && !hi_valid) else $error("move to low after multiply wrong");
   smul_res_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_SIGNED_MULTIPLY
      |-> ##3 lo_out == {{32{$past(sprod[31], 3)}}, $past(sprod[31:0], 3)}
          && hi_out == {{32{$past(sprod[63], 3)}}, $past(sprod[63:32], 3)}) else $error("signed product wrong");
   umul_res_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_UNSIGNED_MULTIPLY
      |-> ##3 lo_out[31:0] == $past(uprod[31:0], 3) && hi_out[31:0] == $past(uprod[63:32], 3))
      else $error("unsigned product wrong");
   nor_res_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_NOR
      |=> gpr_wr_en && gpr_wr_data == ~($past(src_a) | $past(src_b))) else $error("nor result wrong");
   or_res_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_OR
      |=> gpr_wr_en && gpr_wr_data == ($past(src_a) | $past(src_b))) else $error("or result wrong");
   cop_half_a: assert property (cop_wr_en |-> cop_wr_hi == $past(f_rd[0])
      && cop_wr_data == $past(src_b[31:0])) else $error("coprocessor half select wrong");
   hilo_undef_a: assert property (fire && op == `LMM_OP_SPECIAL && fn == `LMM_FN_SIGNED_MULTIPLY
      |=> (!hi_valid && !lo_valid)[*2]) else $error("product flagged valid too early");
   cov_load_c: cover property (s_r.st == ST_LOAD && mem_ack ##1 gpr_wr_en);
   cov_mul_move_to_product_high_c: cover property (fire && fn == `LMM_FN_SIGNED_MULTIPLY ##3 fire && fn == `LMM_FN_MOVE_TO_PRODUCT_HIGH);
   cov_coprd_c: cover property (s_r.st == ST_COPRD ##1 gpr_wr_en);
   cov_cop3_c: cover property (exc_valid && exc_code == `LMM_EXC_RSVD);
endmodule

// *** lmm_tb.sv ***
`timescale 1ns/10ps
`include "lmm_regs.svh"
module tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ins_valid = 1'b0;
   logic        mem_ack = 1'b0;
   logic        mem_tlb_refill = 1'b0;
   logic        mem_tlb_invalid = 1'b0;
   logic        mem_bus_err = 1'b0;
   logic [31:0] ins_word = 32'h0;
   logic [31:0] mem_rdata = 32'h0;
   logic [63:0] src_a = 64'h0;
   logic [63:0] src_b = 64'h0;
   logic [63:0] cop_rd_data = 64'h0;
   logic [3:0]  cop_usable = 4'hD;
   logic        ins_ready, mem_req, cp0_wr_en, cop_wr_en, cop_wr_hi, gpr_wr_en, exc_valid, hi_valid, lo_valid;
   logic [63:0] mem_addr, cp0_wr_data, gpr_wr_data, hi_out, lo_out;
   logic [1:0]  cop_rd_num, cop_wr_num;
   logic [4:0]  cop_rd_idx, cp0_wr_idx, gpr_wr_idx;
   logic [3:0]  cop_wr_idx, exc_code;
   logic [31:0] cop_wr_data;
   int          err_total = 0;
   int          n_tests = 0;
   int          cyc = 0;

   lmm_exec dut (.ref_clk, .rst, .ins_valid, .ins_ready, .ins_word, .src_a, .src_b, .cop_usable, .mem_req,
                 .mem_addr, .mem_ack, .mem_rdata, .mem_tlb_refill, .mem_tlb_invalid, .mem_bus_err, .cop_rd_num,
                 .cop_rd_idx, .cop_rd_data, .cp0_wr_en, .cp0_wr_idx, .cp0_wr_data, .cop_wr_en, .cop_wr_num,
                 .cop_wr_idx, .cop_wr_hi, .cop_wr_data, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .exc_valid,
                 .exc_code, .hi_out, .lo_out, .hi_valid, .lo_valid);

   always #20 ref_clk = ~ref_clk;

   task automatic stop_test();
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Ceiling is many times the fewer than a hundred cycles the scenarios need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask

   // Returns at the falling edge after the taking edge, where one-cycle answers stand
   task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
      int i;
      @(negedge ref_clk);
      ins_word = w;
      src_a = a;
      src_b = b;
      ins_valid = 1'b1;
      i = 0;
      while (ins_ready !== 1'b1 && i < 100) begin
         @(negedge ref_clk);
         i++;
      end
      if (ins_ready !== 1'b1) begin
         $display("[FAIL] ins_ready expected 1 seen %b", ins_ready);
         err_total++;
      end
      @(posedge ref_clk);
      @(negedge ref_clk);
      ins_valid = 1'b0;
   endtask

   task automatic t_logic();
      issue({`LMM_OP_SPECIAL, 5'h03, 5'h04, 5'h05, 5'h00, `LMM_FN_OR}, 64'hF0F0_0000_1234_0001,
            64'h0F00_8000_0000_0010);
      chk("or_en", 1, gpr_wr_en);
      chk("or_idx", 5, gpr_wr_idx);
      chk("or_data", 64'hFFF0_8000_1234_0011, gpr_wr_data);
      issue({`LMM_OP_SPECIAL, 5'h03, 5'h04, 5'h1F, 5'h00, `LMM_FN_NOR}, 64'hF0F0_0000_1234_0001,
            64'h0F00_8000_0000_0010);
      chk("nor_idx", 5'h1F, gpr_wr_idx);
      chk("nor_data", 64'h000F_7FFF_EDCB_FFEE, gpr_wr_data);
   endtask

   task automatic mem_resp(input logic [2:0] flt, input logic [31:0] d);
      repeat (2) @(negedge ref_clk);
      mem_ack = 1'b1;
      mem_rdata = d;
      {mem_tlb_refill, mem_tlb_invalid, mem_bus_err} = flt;
      @(negedge ref_clk);
      mem_ack = 1'b0;
      {mem_tlb_refill, mem_tlb_invalid, mem_bus_err} = 3'h0;
   endtask

   task automatic t_load();
      logic [3:0] codes [3] = '{`LMM_EXC_REFILL, `LMM_EXC_INVALID, `LMM_EXC_BUS};
      // Negative offset exercises the sign extension of the displacement
      issue({`LMM_OP_LWU, 5'h02, 5'h09, 16'hFFF8}, 64'h0000_0001_0000_0100, 64'h0);
      chk("ld_req", 1, mem_req);
      chk("ld_addr", 64'h0000_0001_0000_00F8, mem_addr);
      mem_resp(3'h0, 32'h8765_4321);
      chk("ld_wr", 1, gpr_wr_en);
      chk("ld_idx", 9, gpr_wr_idx);
      chk("ld_data", 64'h0000_0000_8765_4321, gpr_wr_data);
      for (int f = 0; f < 3; f++) begin
         issue({`LMM_OP_LWU, 5'h02, 5'h09, 16'h0004}, 64'h100, 64'h0);
         mem_resp(3'h4 >> f, 32'h1);
         chk("flt_exc", 1, exc_valid);
         chk("flt_code", codes[f], exc_code);
         chk("flt_nowr", 0, gpr_wr_en);
      end
      issue({`LMM_OP_LWU, 5'h02, 5'h09, 16'h0002}, 64'h100, 64'h0);
      chk("mis_req", 0, mem_req);
      chk("mis_exc", 1, exc_valid);
      chk("mis_code", `LMM_EXC_ADDR, exc_code);
   endtask

   task automatic t_cop();
      cop_rd_data = 64'h1234_5678_8000_00A5;
      issue({`LMM_OP_COP_GRP, `LMM_COP_SYSCTL, `LMM_COP_MF, 5'h06, 5'h0C, 11'h0}, 64'h0, 64'h0);
      chk("mf_num", 0, cop_rd_num);
      chk("mf_idx", 5'h0C, cop_rd_idx);
      chk("mf_early", 0, gpr_wr_en);
      @(negedge ref_clk);
      chk("mf_wr", 1, gpr_wr_en);
      chk("mf_data", 64'hFFFF_FFFF_8000_00A5, gpr_wr_data);
      issue({`LMM_OP_COP_GRP, `LMM_COP_RSVD, `LMM_COP_MF, 5'h06, 5'h0C, 11'h0}, 64'h0, 64'h0);
      chk("c3_code", `LMM_EXC_RSVD, exc_code);
      // Coprocessor 1 is marked unusable by cop_usable
      issue({`LMM_OP_COP_GRP, 2'h1, `LMM_COP_MT, 5'h06, 5'h0C, 11'h0}, 64'h0, 64'h5);
      chk("c1_exc", 1, exc_valid);
      chk("c1_code", `LMM_EXC_UNUSE, exc_code);
      chk("c1_nowr", 0, cop_wr_en);
      issue({`LMM_OP_COP_GRP, 2'h2, `LMM_COP_MT, 5'h06, 5'h07, 11'h0}, 64'h0, 64'hAAAA_BBBB_CCCC_DDDD);
      chk("mt_en", 1, cop_wr_en);
      chk("mt_num", 2, cop_wr_num);
      chk("mt_idx", 3, cop_wr_idx);
      chk("mt_hi", 1, cop_wr_hi);
      chk("mt_data", 64'hCCCC_DDDD, cop_wr_data);
      // Neighbours of this move are coprocessor moves and a multiply, never a memory access
      issue({`LMM_OP_COP_GRP, `LMM_COP_SYSCTL, `LMM_COP_MT, 5'h06, 5'h0E, 11'h0}, 64'h0,
            64'h0123_4567_89AB_CDEF);
      chk("m0_en", 1, cp0_wr_en);
      chk("m0_idx", 5'h0E, cp0_wr_idx);
      chk("m0_data", 64'h0123_4567_89AB_CDEF, cp0_wr_data);
   endtask

   // Product write: the written registers are flagged invalid until the third edge commits
   task automatic prod(input logic [5:0] fn, input logic [63:0] a, input logic [63:0] b, input logic [63:0] eh,
                       input logic [63:0] el, input logic vh, input logic vl);
      logic ph;
      logic pl;
      ph = hi_valid;
      pl = lo_valid;
      issue({`LMM_OP_SPECIAL, 5'h01, 5'h02, 10'h0, fn}, a, b);
      chk("busy", 0, ins_ready);
      // A move leaves the flag of the other half standing until its commit
      chk("wait_hv", (fn == `LMM_FN_MOVE_TO_PRODUCT_LOW) ? ph : 1'b0, hi_valid);
      chk("wait_lv", (fn == `LMM_FN_MOVE_TO_PRODUCT_HIGH) ? pl : 1'b0, lo_valid);
      repeat (2) @(negedge ref_clk);
      chk("hi_valid", vh, hi_valid);
      chk("lo_valid", vl, lo_valid);
      if (vh) chk("hi_out", eh, hi_out);
      if (vl) chk("lo_out", el, lo_out);
   endtask

   task automatic t_prod();
      prod(`LMM_FN_SIGNED_MULTIPLY, 64'hFFFF_FFFF_FFFF_FFFD, 64'h7, 64'hFFFF_FFFF_FFFF_FFFF,
           64'hFFFF_FFFF_FFFF_FFEB, 1, 1);
      prod(`LMM_FN_MOVE_TO_PRODUCT_HIGH, 64'h1111_2222_3333_4444, 64'h0, 64'h1111_2222_3333_4444, 64'h0, 1, 0);
      prod(`LMM_FN_MOVE_TO_PRODUCT_LOW, 64'h5555_6666_7777_8888, 64'h0, 64'h1111_2222_3333_4444,
           64'h5555_6666_7777_8888, 1, 1);
      issue({`LMM_OP_SPECIAL, 10'h0, 5'h0B, 5'h00, `LMM_FN_MOVE_FROM_PRODUCT_HIGH}, 64'h0, 64'h0);
      chk("move_from_product_high", 64'h1111_2222_3333_4444, gpr_wr_data);
      issue({`LMM_OP_SPECIAL, 10'h0, 5'h0B, 5'h00, `LMM_FN_MOVE_FROM_PRODUCT_LOW}, 64'h0, 64'h0);
      chk("move_from_product_low", 64'h5555_6666_7777_8888, gpr_wr_data);
      // Two unrelated instructions keep the product reads clear of the next multiply
      issue({`LMM_OP_SPECIAL, 5'h03, 5'h04, 5'h05, 5'h00, `LMM_FN_OR}, 64'h0, 64'h0);
      issue({`LMM_OP_SPECIAL, 5'h03, 5'h04, 5'h05, 5'h00, `LMM_FN_OR}, 64'h0, 64'h0);
      prod(`LMM_FN_UNSIGNED_MULTIPLY, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2, 64'h1, 64'hFFFF_FFFF_FFFF_FFFE, 1, 1);
      prod(`LMM_FN_MOVE_TO_PRODUCT_LOW, 64'h0000_0000_0000_0042, 64'h0, 64'h0, 64'h42, 0, 1);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_logic();
      t_load();
      t_cop();
      t_prod();
      stop_test();
   end
endmodule
